/* hdl/adc_seq_pkg.sv */
/*
 package for the converter power sequencing block: states, frame counts,
 timing constants and the carrier structs.
 assumes a 20 MHz system clock.
*/
package adc_seq_pkg;

   // ****************************************
   // frame counts
   // ****************************************
   localparam int unsigned FRAME_EDGES = 16;
   localparam int unsigned PD_LOW_EDGE = 2;
   localparam int unsigned PD_HIGH_EDGE = 10;
   localparam int unsigned TRACK_EDGE = 13;
   localparam int unsigned LEAD_ZEROS = 4;
   localparam int unsigned RESULT_BITS = 12;

   // ****************************************
   // timing
   // ****************************************
   localparam int unsigned CLK_HZ = 20000000;
   localparam int unsigned POWER_UP_NS = 1000;
   localparam int unsigned POWER_UP_CYCLES = (POWER_UP_NS * (CLK_HZ / 1000000) + 999) / 1000;

   // ****************************************
   // power state
   // ****************************************
   typedef enum logic [1:0] {
      PWR_DOWN = 2'b00,
      PWR_WAKING = 2'b01,
      PWR_FULL = 2'b10
   } power_state_t;

   typedef struct packed {
      logic chip_select_n;
      logic serial_clock;
   } link_in_t;

   typedef struct packed {
      logic data;
      logic data_oe;
   } link_out_t;

endpackage : adc_seq_pkg

/* hdl/edge_sync.sv */
/*
 two-flop synchroniser with rise and fall pulses taken from the second flop.
 assumes an asynchronous level input.
*/
`timescale 1ns/1ps
`default_nettype none
module edge_sync #(
   // level the pin rests at when idle, loaded at reset so that no false edge follows
   parameter logic IDLE = 1'b1
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic nrst_i,
   // async level
   input wire logic async_i,
   // synchronised level and edges
   output logic level_o,
   output logic rise_o,
   output logic fall_o
);
   logic stage1;
   logic stage2;
   logic stage3;
   logic next_stage1;
   logic next_stage2;
   logic next_stage3;

   always_comb begin
      next_stage1 = async_i;
      next_stage2 = stage1;
      next_stage3 = stage2;
   end

   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         stage1 <= IDLE;
         stage2 <= IDLE;
         stage3 <= IDLE;
      end else begin
         stage1 <= next_stage1;
         stage2 <= next_stage2;
         stage3 <= next_stage3;
      end
   end

   assign level_o = stage2;
   assign rise_o = stage2 & ~stage3;
   assign fall_o = ~stage2 & stage3;
endmodule : edge_sync
`default_nettype wire

/* hdl/adc_power_up_sequencing.sv */
/*
 converter frame and power sequencing: chip select framing, falling-edge
 counting, power mode, track/hold and serial result shifting.
 assumes chip select and serial clock arrive from the host asynchronously
 and are much slower than clk_i; the result word arrives on clk_i.
*/
// What this block does
// - one dummy frame fully powers the converter
// - wake: track on first clock after select
// - power up and acquire in one frame
// - initial power state undefined after supply
// - supply power-up time equals wake time
// - at supply start tracking already on
// - release in edges two..nine powers down
// - wake continues only past tenth edge
// - sixteen clocks; output enable window
// - four zeros then twelve bits MSB first
`timescale 1ns/1ps
`default_nettype none
module adc_power_up_sequencing
   import adc_seq_pkg::*;
#(
   parameter int unsigned WAKE_CYCLES = POWER_UP_CYCLES
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic nrst_i,
   // host link pins
   input wire link_in_t link_i,
   output link_out_t link_o,
   // supply start-up power state strap
   input wire logic start_powered_i,
   // conversion result from the analog core
   input wire logic [RESULT_BITS-1:0] sample_i,
   // status
   output logic powered_o,
   output logic tracking_o,
   output logic sample_o
);
   if (WAKE_CYCLES < 1 || WAKE_CYCLES > 65535) begin : g_bad_wake
      $error("WAKE_CYCLES out of range");
   end

   // ****************************************
   // link synchronisers
   // ****************************************
   logic cs_level;
   logic cs_rise;
   logic cs_fall;
   logic sclk_rise;
   logic sclk_fall;

   edge_sync #(
      .IDLE(1'b1)
   ) u_cs (
      .clk_i(clk_i),
      .nrst_i(nrst_i),
      .async_i(link_i.chip_select_n),
      .level_o(cs_level),
      .rise_o(cs_rise),
      .fall_o(cs_fall)
   );

   // serial clock rests low between frames
   edge_sync #(
      .IDLE(1'b0)
   ) u_sclk (
      .clk_i(clk_i),
      .nrst_i(nrst_i),
      .async_i(link_i.serial_clock),
      .level_o(),
      .rise_o(sclk_rise),
      .fall_o(sclk_fall)
   );

   // ****************************************
   // frame and power state
   // ****************************************
   power_state_t pstate;
   power_state_t next_pstate;
   logic [4:0] edges;
   logic [4:0] next_edges;
   logic in_frame;
   logic next_in_frame;
   logic woke_frame;
   logic next_woke_frame;
   logic [15:0] wake_cnt;
   logic [15:0] next_wake_cnt;
   logic [15:0] shreg;
   logic [15:0] next_shreg;
   logic data;
   logic next_data;
   logic data_oe;
   logic next_data_oe;
   logic tracking;
   logic next_tracking;
   logic sample;
   logic next_sample;
   logic strap_taken;
   logic next_strap_taken;

   always_comb begin
      next_pstate = pstate;
      next_edges = edges;
      next_in_frame = in_frame;
      next_woke_frame = woke_frame;
      next_wake_cnt = wake_cnt;
      next_shreg = shreg;
      next_data = data;
      next_data_oe = data_oe;
      next_tracking = tracking;
      next_sample = 1'b0;
      next_strap_taken = 1'b1;
      if (!strap_taken) begin
         // undefined supply state resolved by the strap; track already on
         next_pstate = start_powered_i ? PWR_WAKING : PWR_DOWN;
         next_wake_cnt = 16'(WAKE_CYCLES);
         next_tracking = 1'b1;
      end else begin
         if (pstate == PWR_WAKING) begin
            if (wake_cnt <= 16'h0001) begin
               next_pstate = PWR_FULL;
               next_wake_cnt = 16'h0000;
            end else begin
               next_wake_cnt = wake_cnt - 16'h0001;
            end
         end
         if (cs_fall && !in_frame) begin
            next_in_frame = 1'b1;
            next_edges = 5'h00;
            next_tracking = 1'b0;
            next_sample = 1'b1;
            next_data_oe = 1'b1;
            next_data = 1'b0;
            next_shreg = {4'h0, sample_i};
            next_woke_frame = (pstate == PWR_DOWN);
            if (pstate == PWR_DOWN) begin
               next_pstate = PWR_WAKING;
               next_wake_cnt = 16'(WAKE_CYCLES);
            end
         end else if (in_frame && cs_rise) begin
            next_in_frame = 1'b0;
            next_data_oe = 1'b0;
            next_tracking = 1'b1;
            if (woke_frame && edges < 5'(PD_HIGH_EDGE)) begin
               next_pstate = PWR_DOWN;
            end else if (!woke_frame && edges >= 5'(PD_LOW_EDGE) && edges < 5'(PD_HIGH_EDGE)) begin
               next_pstate = PWR_DOWN;
            end
         end else if (in_frame) begin
            if (woke_frame && sclk_rise && edges == 5'h00) begin
               next_tracking = 1'b1;
            end
            if (sclk_rise && edges == 5'(TRACK_EDGE)) begin
               next_tracking = 1'b1;
            end
            if (sclk_fall && edges < 5'(FRAME_EDGES)) begin
               next_edges = edges + 5'h01;
               next_shreg = {shreg[14:0], 1'b0};
               next_data = shreg[14];
               if (edges == 5'(FRAME_EDGES - 1)) begin
                  next_data_oe = 1'b0;
                  next_tracking = 1'b1;
               end
            end
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         pstate <= PWR_DOWN;
         edges <= 5'h00;
         in_frame <= 1'b0;
         woke_frame <= 1'b0;
         wake_cnt <= 16'h0000;
         shreg <= 16'h0000;
         data <= 1'b0;
         data_oe <= 1'b0;
         tracking <= 1'b1;
         sample <= 1'b0;
         strap_taken <= 1'b0;
      end else begin
         pstate <= next_pstate;
         edges <= next_edges;
         in_frame <= next_in_frame;
         woke_frame <= next_woke_frame;
         wake_cnt <= next_wake_cnt;
         shreg <= next_shreg;
         data <= next_data;
         data_oe <= next_data_oe;
         tracking <= next_tracking;
         sample <= next_sample;
         strap_taken <= next_strap_taken;
      end
   end

   // ****************************************
   // outputs
   // ****************************************
   logic powered;
   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         powered <= 1'b0;
      end else begin
         powered <= (next_pstate == PWR_FULL);
      end
   end

   assign link_o.data = data;
   assign link_o.data_oe = data_oe;
   assign powered_o = powered;
   assign tracking_o = tracking;
   assign sample_o = sample;

   // ****************************************
   // checks
   // ****************************************
   sequence s_early_release;
      in_frame && cs_rise && !woke_frame && edges >= 5'(PD_LOW_EDGE) && edges < 5'(PD_HIGH_EDGE);
   endsequence

   a_power_down_window: assert property (@(posedge clk_i) disable iff (!nrst_i)
      s_early_release |=> pstate == PWR_DOWN)
      else $error("early release did not power down");

   a_glitch_keeps_mode: assert property (@(posedge clk_i) disable iff (!nrst_i)
      (in_frame && cs_rise && !woke_frame && edges < 5'(PD_LOW_EDGE)) |=> pstate == $past(pstate))
      else $error("glitch release changed mode");

   a_wake_abort: assert property (@(posedge clk_i) disable iff (!nrst_i)
      (in_frame && cs_rise && woke_frame && edges < 5'(PD_HIGH_EDGE)) |=> pstate == PWR_DOWN)
      else $error("short wake frame did not return to power-down");

   a_wake_track: assert property (@(posedge clk_i) disable iff (!nrst_i)
      (in_frame && woke_frame && sclk_rise && edges == 5'h00 && !cs_rise) |=> tracking)
      else $error("track not resumed on first clock");

   a_oe_drop_16: assert property (@(posedge clk_i) disable iff (!nrst_i)
      (in_frame && sclk_fall && !cs_rise && edges == 5'(FRAME_EDGES - 1)) |=> !data_oe)
      else $error("output enable not released at edge sixteen");

   a_oe_on_select: assert property (@(posedge clk_i) disable iff (!nrst_i)
      (strap_taken && cs_fall && !in_frame) |=> data_oe && !data)
      else $error("output not enabled with leading zero");

   a_lead_zeros: assert property (@(posedge clk_i) disable iff (!nrst_i)
      (in_frame && data_oe && edges < 5'(LEAD_ZEROS)) |-> !data)
      else $error("leading zero violated");

   a_full_power: assert property (@(posedge clk_i) disable iff (!nrst_i)
      (pstate == PWR_WAKING && wake_cnt == 16'h0001 && !cs_rise && !cs_fall) |=> pstate == PWR_FULL)
      else $error("wake time not honoured");

   a_start_track: assert property (@(posedge clk_i) disable iff (!nrst_i)
      (!strap_taken) |=> tracking)
      else $error("not tracking at start");
endmodule : adc_power_up_sequencing
`default_nettype wire

/* testbench/host_port_model.sv */
/*
 host serial port model: frames chip select, runs the serial clock and
 reads the result word.
 assumes the block's clk_i; serial clock half period is 4 clk (200 ns).
*/
`timescale 1ns/1ps
`default_nettype none
module host_port_model
   import adc_seq_pkg::*;
(
   // clock
   input wire logic clk_i,
   // link to the converter
   output link_in_t link_o,
   input wire link_out_t link_i
);
   logic last_bit = 1'b0;
   logic line;
   logic [15:0] word;
   // a released line shows the inverse of its last driven value
   assign line = link_i.data_oe ? link_i.data : ~last_bit;
   always @(posedge clk_i) begin
      if (link_i.data_oe) begin
         last_bit <= link_i.data;
      end
   end
   initial link_o = '{chip_select_n: 1'b1, serial_clock: 1'b0};
   // whole clk periods only, so serial clock edges come at equal intervals
   // slow serial clock keeps the frame rate far below the fast-rate limit
   task automatic half();
      repeat (4) @(posedge clk_i);
   endtask : half
   // frame of n falling serial edges, chip select low only inside it
   task automatic frame(input int n);
      @(posedge clk_i);
      link_o.chip_select_n <= 1'b0;
      word = '0;
      half();
      for (int k = 1; k <= n; k++) begin
         link_o.serial_clock <= 1'b1;
         half();
         word = {word[14:0], line};
         link_o.serial_clock <= 1'b0;
         half();
      end
      link_o.chip_select_n <= 1'b1;
      repeat (8) @(posedge clk_i);
   endtask : frame
endmodule : host_port_model
`default_nettype wire

/* testbench/adc_power_up_sequencing_tb_top.sv */
/*
 testbench for the converter power sequencing block.
 assumes host_port_model as the far side and the default wake count.
*/
`timescale 1ns/1ps
`default_nettype none
module adc_power_up_sequencing_tb_top
   import adc_seq_pkg::*;
;
   logic clk_i = 1'b0;
   logic nrst_i = 1'b0;
   logic start_powered = 1'b1;
   logic [RESULT_BITS-1:0] sample = 12'h000;
   link_in_t link_in;
   link_out_t link_out;
   logic powered;
   logic tracking;
   logic sample_pulse;
   int bad_count = 0;
   int n_tests = 0;
   int cycles = 0;
   int pulses = 0;

   adc_power_up_sequencing u_dut (.clk_i(clk_i), .nrst_i(nrst_i), .link_i(link_in), .link_o(link_out),
      .start_powered_i(start_powered), .sample_i(sample), .powered_o(powered), .tracking_o(tracking),
      .sample_o(sample_pulse));
   host_port_model u_host (.clk_i(clk_i), .link_o(link_in), .link_i(link_out));

   initial begin
      forever #25 clk_i = ~clk_i;
   end
   always @(posedge clk_i) begin
      cycles <= cycles + 1;
      if (sample_pulse === 1'b1) begin
         pulses <= pulses + 1;
      end
      if (cycles == 5000) begin
         bad_count++;
         print_verdict();
      end
   end

   // ****************************************
   // helpers
   // ****************************************
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_tests++;
      if (got !== exp) begin
         bad_count++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic do_reset(input logic strap);
      @(posedge clk_i);
      nrst_i <= 1'b0;
      start_powered <= strap;
      repeat (3) @(posedge clk_i);
      nrst_i <= 1'b1;
      #1;
      chk(16'(tracking), 16'h0001);
      chk(16'(link_out.data_oe), 16'h0000);
      repeat (POWER_UP_CYCLES / 2) @(posedge clk_i);
      #1;
      chk(16'(powered), 16'h0000);
      repeat (POWER_UP_CYCLES) @(posedge clk_i);
      #1;
      chk(16'(powered), 16'(strap));
   endtask : do_reset
   // frame of n edges; tracking checked before and after the first rise
   task automatic run(input int n, input logic wake, input logic [11:0] val);
      int p;
      p = pulses;
      @(posedge clk_i);
      sample <= val;
      fork
         u_host.frame(n);
         begin
            repeat (7) @(posedge clk_i);
            #1;
            chk(16'(tracking), 16'h0000);
            repeat (4) @(posedge clk_i);
            #1;
            chk(16'(tracking), 16'(wake));
         end
      join
      #1;
      chk(16'(pulses - p), 16'h0001);
      chk(16'(link_out.data_oe), 16'h0000);
   endtask : run

   // ****************************************
   // scenarios
   // ****************************************
   task automatic t_full();
      run(16, 1'b0, 12'hA5C);
      chk(u_host.word, 16'h0A5C);
      chk(16'(tracking), 16'h0001);
      chk(16'(powered), 16'h0001);
      $display("test full done");
   endtask : t_full
   task automatic t_keep();
      run(1, 1'b0, 12'h123);
      chk(16'(powered), 16'h0001);
      run(12, 1'b0, 12'hFFF);
      chk(16'(powered), 16'h0001);
      $display("test keep done");
   endtask : t_keep
   task automatic t_down();
      run(8, 1'b0, 12'h5A5);
      chk(16'(powered), 16'h0000);
      run(9, 1'b1, 12'h0F0);
      chk(16'(powered), 16'h0000);
      $display("test down done");
   endtask : t_down
   task automatic t_wake();
      run(10, 1'b1, 12'h001);
      chk(16'(powered), 16'h0001);
      run(16, 1'b0, 12'h3F1);
      chk(u_host.word, 16'h03F1);
      $display("test wake done");
   endtask : t_wake
   task automatic t_cold();
      do_reset(1'b0);
      run(16, 1'b1, 12'h800);
      chk(16'(powered), 16'h0001);
      run(16, 1'b0, 12'h800);
      chk(u_host.word, 16'h0800);
      $display("test cold done");
   endtask : t_cold

   task automatic print_verdict();
      $display("checks %0d mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : print_verdict

   initial begin
      do_reset(1'b1);
      t_full();
      t_keep();
      t_down();
      t_wake();
      t_cold();
      print_verdict();
   end
endmodule : adc_power_up_sequencing_tb_top
`default_nettype wire
